// File: rtl/pwm_output_steering.sv
// pwm output steering stage: routes the modulated pwm onto four output pins
// assumes timebase, dead-band and shutdown logic share pclk; registers over apb
`include "pwm_steer_params.svh"
`timescale 1ns/1ps
`default_nettype none

module pwm_output_steering
	import pwm_steer_pkg::*;
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               ce,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [`ADDR_W-1:0] paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               pwm_mod,
	input  wire logic               pwm_dead_a,
	input  wire logic               pwm_dead_b,
	input  wire logic               period_start,
	input  wire logic               shutdown_active,
	input  wire logic [3:0]         port_data,
	output logic                    pwm_out_a,
	output logic                    pwm_out_b,
	output logic                    pwm_out_c,
	output logic                    pwm_out_d,
	output logic [3:0]              pin_pwm_owned
);

	ccp_ctrl_t   ccp_control_reg_q;
	steer_ctrl_t steering_control_reg_q;
	logic [3:0]  steer_active_q;
	logic [3:0]  steer_pending_q;
	logic        pending_valid_q;
	logic [3:0]  pins_q;
	logic [3:0]  owned_q;

	logic        access;
	logic        wr_ccp;
	logic        wr_steer;
	logic        pwm_mode;
	logic        steering_mode;
	logic        pol_ac_low;
	logic        pol_bd_low;
	logic [3:0]  pins_d;
	logic [3:0]  owned_d;
	drive_kind_t kind [4];

	// address decode, used by both read and write paths
	function automatic logic [1:0] reg_sel(input logic [`ADDR_W-1:0] a);
		if (a == `OFF_CCP_CONTROL) begin
			reg_sel = 2'h1;
		end else if (a == `OFF_STEERING) begin
			reg_sel = 2'h2;
		end else if (a == `OFF_STEER_STATUS) begin
			reg_sel = 2'h3;
		end else begin
			reg_sel = 2'h0;
		end
	endfunction : reg_sel

	// slave answers in the first access cycle unless the block is frozen
	assign pready   = ce;
	assign access   = psel && penable && ce;
	assign pslverr  = psel && penable && (reg_sel(paddr) == 2'h0);
	assign wr_ccp   = access && pwrite && (reg_sel(paddr) == 2'h1);
	assign wr_steer = access && pwrite && (reg_sel(paddr) == 2'h2);

	// read data registered so prdata is a flop output; valid in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (ce && psel && !penable && !pwrite) begin
			case (reg_sel(paddr))
				2'h1:    prdata <= {24'h00_0000, ccp_control_reg_q};
				2'h2:    prdata <= {27'h000_0000, steering_control_reg_q};
				2'h3:    prdata <= {23'h00_0000, pending_valid_q, steer_pending_q, steer_active_q};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ccp_control_reg_q <= `CCP_CONTROL_RESET;
		end else if (wr_ccp) begin
			ccp_control_reg_q <= pwdata[7:0];
		end
	end

	// steering register as software sees it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			steering_control_reg_q <= `STEERING_RESET;
		end else if (wr_steer) begin
			steering_control_reg_q <= pwdata[4:0];
		end
	end

	// active enables: immediate on unsynced write, else at period start
	// an immediate write may cut a pulse short; that is the point of it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			steer_active_q <= `STEER_EN_RESET;
		end else if (ce) begin
			if (wr_steer && !pwdata[`STEER_SYNC_BIT]) begin
				steer_active_q <= pwdata[3:0];
			end else if (period_start && pending_valid_q) begin
				steer_active_q <= steer_pending_q;
			end
		end
	end

	// pending holder; a synced write in the rollover cycle waits for the next one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			steer_pending_q <= `STEER_EN_RESET;
			pending_valid_q <= 1'b0;
		end else if (ce) begin
			if (wr_steer && pwdata[`STEER_SYNC_BIT]) begin
				steer_pending_q <= pwdata[3:0];
				pending_valid_q <= 1'b1;
			end else if (wr_steer) begin
				steer_pending_q <= pwdata[3:0];
				pending_valid_q <= 1'b0;
			end else if (period_start) begin
				pending_valid_q <= 1'b0;
			end
		end
	end

	// mode decode; polarity bits: bit1 for a/c, bit0 for b/d active-low
	assign pwm_mode      = (ccp_control_reg_q.unit_mode_field[3:2] == `MODE_PWM_HI);
	assign steering_mode = pwm_mode && (ccp_control_reg_q.output_config_field == `CFG_SINGLE);
	assign pol_ac_low    = ccp_control_reg_q.unit_mode_field[1];
	assign pol_bd_low    = ccp_control_reg_q.unit_mode_field[0];

	// per-pin drive kind from output configuration
	always_comb begin
		kind[0] = DRIVE_PORT;
		kind[1] = DRIVE_PORT;
		kind[2] = DRIVE_PORT;
		kind[3] = DRIVE_PORT;
		if (pwm_mode) begin
			case (ccp_control_reg_q.output_config_field)
				`CFG_SINGLE: begin
					for (int i = 0; i < 4; i++) begin
						// reset enables leave only a modulated
						kind[i] = steer_active_q[i] ? DRIVE_MOD : DRIVE_PORT;
					end
				end
				`CFG_FULL_FWD: begin
					kind[0] = DRIVE_ACT;
					kind[1] = DRIVE_INACT;
					kind[2] = DRIVE_INACT;
					kind[3] = DRIVE_MOD;
				end
				`CFG_HALF: begin
					kind[0] = DRIVE_MOD;
					kind[1] = DRIVE_MOD;
				end
				default: begin
					kind[0] = DRIVE_INACT;
					kind[1] = DRIVE_MOD;
					kind[2] = DRIVE_ACT;
					kind[3] = DRIVE_INACT;
				end
			endcase
		end
	end

	// pin values; shutdown forces owned pins inactive, port pins untouched
	generate
		for (genvar g = 0; g < 4; g++) begin : g_pin
			logic raw;
			logic pol;
			logic src;
			assign pol = (g == 0 || g == 2) ? pol_ac_low : pol_bd_low;
			// half bridge takes the dead-band pair instead of the plain signal
			assign src = (pwm_mode && ccp_control_reg_q.output_config_field == `CFG_HALF)
				? ((g == 0) ? pwm_dead_a : pwm_dead_b) : pwm_mod;
			always_comb begin
				raw = 1'b0;
				case (kind[g])
					DRIVE_MOD: raw = src;
					DRIVE_ACT: raw = 1'b1;
					default:   raw = 1'b0;
				endcase
			end
			assign owned_d[g] = (kind[g] != DRIVE_PORT);
			assign pins_d[g]  = !owned_d[g] ? port_data[g] :
				(shutdown_active ? pol : (raw ^ pol));
		end
	endgenerate

	// registered pin drive, one cycle behind the sources
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_q  <= 4'h0;
			owned_q <= 4'h0;
		end else if (ce) begin
			pins_q  <= pins_d;
			owned_q <= owned_d;
		end
	end

	assign pwm_out_a     = pins_q[0];
	assign pwm_out_b     = pins_q[1];
	assign pwm_out_c     = pins_q[2];
	assign pwm_out_d     = pins_q[3];
	assign pin_pwm_owned = owned_q;

	// unsynced write lands in the active enables at the next edge
	property p_immediate_steer;
		@(posedge pclk) disable iff (!presetn)
		(wr_steer && !pwdata[`STEER_SYNC_BIT]) |=> (steer_active_q == $past(pwdata[3:0]));
	endproperty
	a_immediate_steer: assert property (p_immediate_steer)
		else $error("unsynced steering write not applied");

	// synced write leaves active enables alone until a period start
	property p_synced_hold;
		@(posedge pclk) disable iff (!presetn)
		(wr_steer && pwdata[`STEER_SYNC_BIT] && !period_start) |=> $stable(steer_active_q);
	endproperty
	a_synced_hold: assert property (p_synced_hold)
		else $error("synced steering applied before period start");

	// pending enables copied in at rollover
	property p_pending_copy;
		@(posedge pclk) disable iff (!presetn)
		(ce && period_start && pending_valid_q && !wr_steer)
			|=> (steer_active_q == $past(steer_pending_q)) && !pending_valid_q;
	endproperty
	a_pending_copy: assert property (p_pending_copy)
		else $error("pending steering not copied at rollover");

	// single output, only a enabled: b c d follow port data
	property p_single_a;
		@(posedge pclk) disable iff (!presetn)
		(ce && steering_mode && steer_active_q == 4'h1)
			|=> (pin_pwm_owned == 4'h1) && ({pwm_out_d, pwm_out_c, pwm_out_b} == $past(port_data[3:1]));
	endproperty
	a_single_a: assert property (p_single_a)
		else $error("single output drove a port pin");

	// forward full bridge pattern
	property p_forward;
		@(posedge pclk) disable iff (!presetn)
		(ce && pwm_mode && ccp_control_reg_q.output_config_field == `CFG_FULL_FWD && !shutdown_active)
			|=> (pwm_out_d == ($past(pwm_mod) ^ $past(pol_bd_low))) && (pwm_out_a == !$past(pol_ac_low))
				&& (pwm_out_b == $past(pol_bd_low)) && (pwm_out_c == $past(pol_ac_low));
	endproperty
	a_forward: assert property (p_forward)
		else $error("forward bridge pattern wrong");

	// half bridge uses the dead-band pair, c and d stay port pins
	property p_half;
		@(posedge pclk) disable iff (!presetn)
		(ce && pwm_mode && ccp_control_reg_q.output_config_field == `CFG_HALF && !shutdown_active)
			|=> (pwm_out_a == ($past(pwm_dead_a) ^ $past(pol_ac_low)))
				&& (pwm_out_b == ($past(pwm_dead_b) ^ $past(pol_bd_low))) && (pin_pwm_owned == 4'h3);
	endproperty
	a_half: assert property (p_half)
		else $error("half bridge pattern wrong");

	// reverse full bridge pattern
	property p_reverse;
		@(posedge pclk) disable iff (!presetn)
		(ce && pwm_mode && ccp_control_reg_q.output_config_field == `CFG_FULL_REV && !shutdown_active)
			|=> (pwm_out_b == ($past(pwm_mod) ^ $past(pol_bd_low))) && (pwm_out_c == !$past(pol_ac_low))
				&& (pwm_out_a == $past(pol_ac_low)) && (pwm_out_d == $past(pol_bd_low));
	endproperty
	a_reverse: assert property (p_reverse)
		else $error("reverse bridge pattern wrong");

	// steered pin carries pwm with polarity from the low mode bits
	property p_steer_polarity;
		@(posedge pclk) disable iff (!presetn)
		(ce && steering_mode && steer_active_q[2] && !shutdown_active)
			|=> pwm_out_c == ($past(pwm_mod) ^ $past(pol_ac_low));
	endproperty
	a_steer_polarity: assert property (p_steer_polarity)
		else $error("steered pin polarity wrong");

	// shutdown leaves unsteered pins on port data
	property p_shutdown_scope;
		@(posedge pclk) disable iff (!presetn)
		(ce && shutdown_active && steering_mode && !steer_active_q[1])
			|=> pwm_out_b == $past(port_data[1]);
	endproperty
	a_shutdown_scope: assert property (p_shutdown_scope)
		else $error("shutdown touched an unsteered pin");

endmodule : pwm_output_steering

`default_nettype wire

// File: rtl/pwm_steer_params.svh
// register offsets, field positions, reset values for the pwm output steering block
// assumes a 32-bit apb slave with byte addresses in paddr
`ifndef PWM_STEER_PARAMS_SVH
`define PWM_STEER_PARAMS_SVH

`define ADDR_W              8
`define OFF_CCP_CONTROL     8'h00
`define OFF_STEERING        8'h04
`define OFF_STEER_STATUS    8'h08

`define CCP_CONTROL_RESET   8'h00
`define STEERING_RESET      5'h01
`define STEER_EN_RESET      4'h1
`define STEER_SYNC_BIT      4
`define STEER_EN_LSB        0

`define MODE_PWM_HI         2'h3
`define CFG_SINGLE          2'h0
`define CFG_FULL_FWD        2'h1
`define CFG_HALF            2'h2
`define CFG_FULL_REV        2'h3

`endif

// File: rtl/pwm_steer_pkg.sv
// types shared by the pwm output steering block
// assumes pwm_steer_params.svh supplies the numeric constants
package pwm_steer_pkg;

	// control register: output config, duty low bits, unit mode
	typedef struct packed {
		logic [1:0] output_config_field;
		logic [1:0] duty_low_bits_field;
		logic [3:0] unit_mode_field;
	} ccp_ctrl_t;

	// steering register: sync select plus enables d..a
	typedef struct packed {
		logic       steer_sync_select;
		logic [3:0] steer_enable;
	} steer_ctrl_t;

	// per-pin drive kinds before polarity is applied
	typedef enum logic [1:0] {
		DRIVE_PORT = 2'b00,
		DRIVE_MOD  = 2'b01,
		DRIVE_ACT  = 2'b10,
		DRIVE_INACT = 2'b11
	} drive_kind_t;

endpackage : pwm_steer_pkg

// File: tb/pwm_load_model.sv
// load model: bridge switches seen as on/off per pin
// assumes pins are plain push-pull levels, d..a
`timescale 1ns/1ps
`default_nettype none

module pwm_load_model (
	input  wire logic       pwm_out_a,
	input  wire logic       pwm_out_b,
	input  wire logic       pwm_out_c,
	input  wire logic       pwm_out_d,
	output logic [3:0]      load_on
);
	// loads follow pins at once, no filtering
	assign load_on = {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a};
endmodule : pwm_load_model

`default_nettype wire

// File: tb/testbench.sv
// testbench for the pwm output steering stage
// assumes apb answers with pready = ce, pins lag state by one edge
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import pwm_steer_pkg::*;
	logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er;
	logic [7:0]  ex;
	logic        pwm_mod = 0, pwm_dead_a = 1, pwm_dead_b = 0, period_start = 0;
	logic        shutdown_active = 0;
	logic [3:0]  port_data = 4'ha, load_on, pin_pwm_owned;
	logic        pa, pb, pc, pd;
	int          mismatches = 0, compares = 0, cyc = 0;

	pwm_output_steering pwm_output_steering_i (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_mod(pwm_mod),
		.pwm_dead_a(pwm_dead_a), .pwm_dead_b(pwm_dead_b), .period_start(period_start),
		.shutdown_active(shutdown_active), .port_data(port_data), .pwm_out_a(pa),
		.pwm_out_b(pb), .pwm_out_c(pc), .pwm_out_d(pd), .pin_pwm_owned(pin_pwm_owned));
	pwm_load_model pwm_load_model_i (.pwm_out_a(pa), .pwm_out_b(pb), .pwm_out_c(pc),
		.pwm_out_d(pd), .load_on(load_on));

	always #50 pclk = ~pclk;

	// hang guard: the whole run needs well under 2000 cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc >= 5000) begin
			mismatches = mismatches + 1;
			summarize();
		end
	end

	task summarize();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize

	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares = compares + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// one apb transfer; held until pready is seen at an edge
	// no wait limit here: only the hang guard ends a stuck access
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0; penable <= 0;
	endtask : apb

	// expected {owned, pins} worked out from config, polarity, enables
	function logic [7:0] expect_pins(logic [1:0] cfg, logic [1:0] pol, logic [3:0] en,
		logic m, logic sd);
		logic [3:0] v, own;
		case (cfg)
			2'h0: begin v = {4{m}}; own = en; end
			2'h1: begin v = {m, 2'b00, 1'b1}; own = 4'hf; end
			2'h2: begin v = {2'b00, pwm_dead_b, pwm_dead_a}; own = 4'h3; end
			default: begin v = {2'b01, m, 1'b0}; own = 4'hf; end
		endcase
		if (sd)
			v = 4'h0;
		v = v ^ {pol[0], pol[1], pol[0], pol[1]};
		return {own, (v & own) | (port_data & ~own)};
	endfunction : expect_pins

	// settle: let the state edge and the pin edge both land
	task settle();
		repeat (2) @(posedge pclk);
		@(negedge pclk);
	endtask : settle

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		settle();
		check(load_on, port_data);
		apb(0, 8'h00, 0); check(rd, 32'h00);
		apb(0, 8'h04, 0); check(rd, 32'h01);
		apb(0, 8'h0c, 0); check(rd, 32'h0);
		check({31'h0, er}, 32'h1);
		apb(1, 8'h00, 32'he5); apb(0, 8'h00, 0); check(rd, 32'he5);
		$display("test registers done");
		// every config with every polarity, shutdown and pwm level
		for (int c = 0; c < 4; c++)
			for (int p = 0; p < 4; p++) begin
				// duty bits 00, mode 11 plus polarity: pwm mode
				apb(1, 8'h00, {c[1:0], 4'h3, p[1:0]});
				for (int k = 0; k < 4; k++) begin
					@(posedge pclk);
					shutdown_active <= k[1];
					pwm_mod <= k[0];
					settle();
					ex = expect_pins(c[1:0], p[1:0], 4'h1, k[0], k[1]);
					check({pin_pwm_owned, load_on}, ex);
				end
			end
		@(posedge pclk);
		shutdown_active <= 0;
		$display("test configs done");
		apb(1, 8'h00, 32'h0c);
		pwm_mod <= 1;
		apb(1, 8'h04, 32'h0f);
		settle();
		check({pin_pwm_owned, load_on}, expect_pins(0, 0, 4'hf, 1, 0));
		apb(1, 8'h04, 32'h13);
		settle();
		check(load_on, 4'hf);
		apb(0, 8'h08, 0); check(rd, 32'h13f);
		@(posedge pclk); period_start <= 1;
		@(posedge pclk); period_start <= 0;
		settle();
		check({pin_pwm_owned, load_on}, expect_pins(0, 0, 4'h3, 1, 0));
		apb(0, 8'h08, 0); check(rd & 32'h10f, 32'h003);
		apb(0, 8'h04, 0); check(rd, 32'h13);
		// frozen clock enable: pins keep their last drive
		ce <= 0;
		pwm_mod <= 0;
		settle();
		check(load_on, 4'hb);
		@(posedge pclk);
		ce <= 1;
		settle();
		check(load_on, 4'h8);
		$display("test steering done");
		summarize();
	end
endmodule : testbench

`default_nettype wire
